// ### core/rwc_pkg.sv
// rwc_pkg: constants, types and register map of the reset and watchdog controller.
// assumes a single 100 MHz bus clock and an AHB-Lite master reaching the registers.
package rwc_pkg;

  // register byte offsets
  localparam logic [7:0] RWC_OFS_CAUSE = 8'h00;
  localparam logic [7:0] RWC_OFS_OPT1 = 8'h04;
  localparam logic [7:0] RWC_OFS_OPT2 = 8'h08;
  localparam logic [7:0] RWC_OFS_WDCNT = 8'h0c;
  localparam logic [7:0] RWC_OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] RWC_OFS_IRQ_FLAG = 8'h14;
  localparam logic [7:0] RWC_OFS_GMASK = 8'h18;
  localparam logic [7:0] RWC_OFS_EXT_MODE = 8'h1c;

  // reset cause bits
  localparam logic [7:0] RWC_CAUSE_POR = 8'h01;
  localparam logic [7:0] RWC_CAUSE_PIN = 8'h02;
  localparam logic [7:0] RWC_CAUSE_WDOG = 8'h04;
  localparam logic [7:0] RWC_CAUSE_ILLEGAL_OPCODE_RESET = 8'h08;
  localparam logic [7:0] RWC_CAUSE_ILLEGAL_ADDRESS_RESET = 8'h10;
  localparam logic [7:0] RWC_CAUSE_LVD = 8'h20;
  localparam logic [7:0] RWC_CAUSE_LOC = 8'h40;
  localparam logic [7:0] RWC_CAUSE_NONE = 8'h00;

  // reset pin timing in bus cycles
  localparam logic [5:0] RWC_PIN_DRIVE_CYCLES = 6'h22;
  localparam logic [5:0] RWC_PIN_SAMPLE_CYCLES = 6'h26;

  // watchdog service values
  localparam logic [31:0] RWC_SVC_FIRST = 32'h0000_0055;
  localparam logic [31:0] RWC_SVC_SECOND = 32'h0000_00aa;

  // option fields and reset values
  localparam int RWC_OPT1_TSEL_LSB = 0;
  localparam int RWC_OPT2_CLKSEL_BIT = 0;
  localparam int RWC_OPT2_WINDOW_BIT = 1;
  localparam logic [1:0] RWC_TSEL_RESET = 2'h3;
  localparam logic [1:0] RWC_TSEL_OFF = 2'h0;
  localparam logic RWC_CLKSEL_RESET = 1'b1;
  localparam logic RWC_WINDOW_RESET = 1'b0;

  // timeouts on the 1 kHz source, in ticks
  localparam logic [19:0] RWC_SLOW_T1 = 20'h00020;
  localparam logic [19:0] RWC_SLOW_T2 = 20'h00100;
  localparam logic [19:0] RWC_SLOW_T3 = 20'h00400;

  // processor-facing constants
  localparam logic [15:0] RWC_RESET_VECTOR = 16'hfffe;
  localparam logic [15:0] RWC_SP_RESET = 16'h00ff;
  localparam logic [15:0] RWC_IRQ_VEC_BASE = 16'hffc0;
  localparam logic [2:0] RWC_STACK_LAST = 3'h4;
  localparam logic [2:0] RWC_VEC_LAST = 3'h1;
  localparam logic [2:0] RWC_FILL_LAST = 3'h2;

  typedef enum logic [1:0] {
    RWC_RS_DRIVE = 2'b00,
    RWC_RS_WAIT = 2'b01,
    RWC_RS_RUN = 2'b10
  } rwc_rst_state_t;

  typedef enum logic [2:0] {
    RWC_SQ_IDLE = 3'b000,
    RWC_SQ_STACK = 3'b001,
    RWC_SQ_VEC = 3'b010,
    RWC_SQ_FILL = 3'b011,
    RWC_SQ_UNSTACK = 3'b100
  } rwc_seq_state_t;

  typedef enum logic [2:0] {
    RWC_OP_NONE = 3'b000,
    RWC_OP_PUSH = 3'b001,
    RWC_OP_PULL = 3'b010,
    RWC_OP_VECTOR = 3'b011,
    RWC_OP_FILL = 3'b100
  } rwc_op_t;

  typedef struct packed {
    logic illegal_opcode;
    logic illegal_address;
    logic low_voltage;
    logic clock_loss;
    logic debug_forced;
  } rwc_rst_src_t;

  // one processor bus step per cycle; index 0..4 of a push is pcl, pch, x, a, ccr
  typedef struct packed {
    rwc_op_t op;
    logic [2:0] index;
    logic [15:0] addr;
  } rwc_cpu_step_t;

endpackage

// ### core/rwc_top.sv
// rwc_top: reset sequencing, reset pin, watchdog and interrupt gating with entry sequencing.
// assumes an AHB-Lite master with single word transfers and synchronous inputs on hclk.
`timescale 1ns/1ps
`default_nettype none
module rwc_top
  import rwc_pkg::*;
#(
  parameter int WDOG_BUS_T1 = 8192,
  parameter int WDOG_BUS_T2 = 65536,
  parameter int WDOG_BUS_T3 = 262144
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire rwc_rst_src_t rst_src,
  input wire logic tick_1khz,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic ext_irq_pin,
  input wire logic [7:1] irq_event,
  input wire logic cpu_instr_done,
  input wire logic cpu_rti,
  output logic cpu_reset_n,
  output logic [15:0] stack_pointer_init,
  output logic global_mask,
  output logic irq_request,
  output rwc_cpu_step_t cpu_step
);

  function automatic logic [19:0] wdog_limit(input logic slow, input logic [1:0] tsel);
    logic [19:0] r;
    r = slow ? RWC_SLOW_T3 : 20'(WDOG_BUS_T3);
    unique case (tsel)
      2'h1: r = slow ? RWC_SLOW_T1 : 20'(WDOG_BUS_T1);
      2'h2: r = slow ? RWC_SLOW_T2 : 20'(WDOG_BUS_T2);
      default: r = slow ? RWC_SLOW_T3 : 20'(WDOG_BUS_T3);
    endcase
    return r;
  endfunction

  function automatic logic [2:0] top_source(input logic [7:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // bus address phase
  logic ph_wr_reg;
  logic [7:0] ph_addr_reg;
  logic [31:0] rdata_reg;
  wire logic addr_ok = hsel & htrans[1] & hready;
  wire logic wr_cause = ph_wr_reg && ph_addr_reg == RWC_OFS_CAUSE;
  wire logic wr_opt1 = ph_wr_reg && ph_addr_reg == RWC_OFS_OPT1;
  wire logic wr_opt2 = ph_wr_reg && ph_addr_reg == RWC_OFS_OPT2;
  wire logic wr_irq_en = ph_wr_reg && ph_addr_reg == RWC_OFS_IRQ_EN;
  wire logic wr_irq_flag = ph_wr_reg && ph_addr_reg == RWC_OFS_IRQ_FLAG;
  wire logic wr_gmask = ph_wr_reg && ph_addr_reg == RWC_OFS_GMASK;
  wire logic wr_ext_mode = ph_wr_reg && ph_addr_reg == RWC_OFS_EXT_MODE;

  // state
  rwc_rst_state_t rst_state_reg;
  logic [5:0] rst_cnt_reg;
  logic [7:0] cause_reg;
  logic [1:0] tsel_reg;
  logic clksel_reg;
  logic window_reg;
  logic opt1_locked_reg;
  logic opt2_locked_reg;
  logic [19:0] wd_cnt_reg;
  logic svc_armed_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] irq_flag_reg;
  logic gmask_reg;
  logic saved_mask_reg;
  logic level_mode_reg;
  logic ext_prev_reg;
  rwc_seq_state_t seq_state_reg;
  logic [2:0] seq_step_reg;
  logic [15:0] vec_addr_reg;
  logic [15:0] sp_reg;

  wire logic sys_rst = rst_state_reg != RWC_RS_RUN;

  // watchdog decode
  wire logic wd_enabled = tsel_reg != RWC_TSEL_OFF;
  wire logic [19:0] wd_limit = wdog_limit(clksel_reg, tsel_reg);
  wire logic wd_hold = debug_mode | stop_mode;
  wire logic wd_tick = clksel_reg ? tick_1khz : 1'b1;
  wire logic wd_window = window_reg & ~clksel_reg;
  wire logic wd_early = wd_cnt_reg < (wd_limit - {2'h0, wd_limit[19:2]});
  wire logic svc_first = hwdata == RWC_SVC_FIRST;
  wire logic svc_second = hwdata == RWC_SVC_SECOND;
  wire logic svc_bad = wr_cause & ~svc_first & ~svc_second;
  wire logic svc_premature = wr_cause & wd_window & wd_early;
  wire logic svc_done = wr_cause & svc_second & svc_armed_reg & ~svc_premature;
  wire logic opt_init = (wr_opt1 & ~opt1_locked_reg) | (wr_opt2 & ~opt2_locked_reg);
  wire logic wd_expire = wd_enabled & ~wd_hold & wd_tick & (wd_cnt_reg >= wd_limit - 20'h1);

  logic [19:0] wd_cnt_next;
  assign wd_cnt_next = (sys_rst | opt_init | svc_done) ? 20'h0 :
                       (clksel_reg & wd_hold) ? 20'h0 :
                       (wd_enabled & ~wd_hold & wd_tick) ? wd_cnt_reg + 20'h1 :
                       wd_cnt_reg;

  // reset causes raised while running, at most one bit
  wire logic wd_reset = wd_expire | svc_bad | svc_premature;
  wire logic [7:0] new_cause = rst_src.low_voltage ? RWC_CAUSE_LVD :
                               rst_src.clock_loss ? RWC_CAUSE_LOC :
                               wd_reset ? RWC_CAUSE_WDOG :
                               rst_src.illegal_opcode ? RWC_CAUSE_ILLEGAL_OPCODE_RESET :
                               rst_src.illegal_address ? RWC_CAUSE_ILLEGAL_ADDRESS_RESET :
                               rst_src.debug_forced ? RWC_CAUSE_NONE : RWC_CAUSE_PIN;
  wire logic reset_trig = !sys_rst && (rst_src.low_voltage | rst_src.clock_loss | wd_reset |
                          rst_src.illegal_opcode | rst_src.illegal_address | rst_src.debug_forced |
                          ~rst_pin_in);

  // reset pin sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_state_reg <= RWC_RS_DRIVE;
      rst_cnt_reg <= 6'h0;
      cause_reg <= RWC_CAUSE_POR;
    end else begin
      unique case (rst_state_reg)
        RWC_RS_RUN: begin
          if (reset_trig) begin
            rst_state_reg <= RWC_RS_DRIVE;
            rst_cnt_reg <= 6'h0;
            cause_reg <= new_cause;
          end
        end
        RWC_RS_DRIVE: begin
          if (rst_cnt_reg == RWC_PIN_DRIVE_CYCLES - 6'h1) begin
            rst_state_reg <= RWC_RS_WAIT;
            rst_cnt_reg <= 6'h0;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 6'h1;
          end
        end
        RWC_RS_WAIT: begin
          // an outside source still holding the pin keeps the chip in reset
          if (rst_cnt_reg < RWC_PIN_SAMPLE_CYCLES - 6'h1) begin
            rst_cnt_reg <= rst_cnt_reg + 6'h1;
          end else if (!rst_pin_in) begin
            cause_reg <= RWC_CAUSE_PIN;
          end else begin
            rst_state_reg <= RWC_RS_RUN;
          end
        end
        default: rst_state_reg <= RWC_RS_DRIVE;
      endcase
    end
  end

  // watchdog and options; bus writes never reach cause_reg
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsel_reg <= RWC_TSEL_RESET;
      clksel_reg <= RWC_CLKSEL_RESET;
      window_reg <= RWC_WINDOW_RESET;
      opt1_locked_reg <= 1'b0;
      opt2_locked_reg <= 1'b0;
      wd_cnt_reg <= 20'h0;
      svc_armed_reg <= 1'b0;
    end else if (sys_rst) begin
      tsel_reg <= RWC_TSEL_RESET;
      clksel_reg <= RWC_CLKSEL_RESET;
      window_reg <= RWC_WINDOW_RESET;
      opt1_locked_reg <= 1'b0;
      opt2_locked_reg <= 1'b0;
      wd_cnt_reg <= 20'h0;
      svc_armed_reg <= 1'b0;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
      if (wr_opt1 && !opt1_locked_reg) begin
        tsel_reg <= hwdata[RWC_OPT1_TSEL_LSB +: 2];
        opt1_locked_reg <= 1'b1;
      end
      if (wr_opt2 && !opt2_locked_reg) begin
        clksel_reg <= hwdata[RWC_OPT2_CLKSEL_BIT];
        window_reg <= hwdata[RWC_OPT2_WINDOW_BIT];
        opt2_locked_reg <= 1'b1;
      end
      if (wr_cause) begin
        svc_armed_reg <= svc_first | (svc_armed_reg & ~svc_second);
      end
    end
  end

  // interrupt flags; a new event beats a clear in the same cycle
  wire logic ext_edge = ext_irq_pin & ~ext_prev_reg;
  wire logic ext_stuck = level_mode_reg & ext_irq_pin;
  wire logic [7:0] flag_set = {irq_event, ext_edge | ext_stuck};
  wire logic [7:0] flag_clr = wr_irq_flag ? (hwdata[7:0] & {7'h7f, ~ext_stuck}) : 8'h00;
  wire logic [7:0] irq_req = irq_flag_reg & irq_en_reg;
  wire logic [2:0] irq_top = top_source(irq_req);
  wire logic take_irq = (seq_state_reg == RWC_SQ_IDLE) & (|irq_req) & ~gmask_reg & cpu_instr_done;
  wire logic take_rti = (seq_state_reg == RWC_SQ_IDLE) & cpu_rti & ~take_irq;
  wire logic unstack_end = (seq_state_reg == RWC_SQ_UNSTACK) & (seq_step_reg == RWC_STACK_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_reg <= 8'h00;
      irq_flag_reg <= 8'h00;
      level_mode_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else if (sys_rst) begin
      irq_en_reg <= 8'h00;
      irq_flag_reg <= 8'h00;
      level_mode_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_irq_pin;
      irq_flag_reg <= flag_set | (irq_flag_reg & ~flag_clr);
      if (wr_irq_en) begin
        irq_en_reg <= hwdata[7:0];
      end
      if (wr_ext_mode) begin
        level_mode_reg <= hwdata[0];
      end
    end
  end

  // global mask: entry sets it, return restores the stacked copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gmask_reg <= 1'b1;
      saved_mask_reg <= 1'b1;
      sp_reg <= RWC_SP_RESET;
    // the mask goes up on the edge that takes a reset, so it is never low while the processor is held
    end else if (sys_rst || reset_trig) begin
      gmask_reg <= 1'b1;
      saved_mask_reg <= 1'b1;
      sp_reg <= RWC_SP_RESET;
    end else begin
      if (take_irq) begin
        saved_mask_reg <= gmask_reg;
        gmask_reg <= 1'b1;
      end else if (unstack_end) begin
        gmask_reg <= saved_mask_reg;
      end else if (wr_gmask) begin
        gmask_reg <= hwdata[0];
      end
    end
  end

  // processor entry sequencer: five pushes, two vector bytes, three fill bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_state_reg <= RWC_SQ_VEC;
      seq_step_reg <= 3'h0;
      vec_addr_reg <= RWC_RESET_VECTOR;
    end else if (sys_rst) begin
      seq_state_reg <= RWC_SQ_VEC;
      seq_step_reg <= 3'h0;
      vec_addr_reg <= RWC_RESET_VECTOR;
    end else begin
      unique case (seq_state_reg)
        RWC_SQ_IDLE: begin
          seq_step_reg <= 3'h0;
          if (take_irq) begin
            seq_state_reg <= RWC_SQ_STACK;
            vec_addr_reg <= RWC_IRQ_VEC_BASE + {12'h0, irq_top, 1'b0};
          end else if (take_rti) begin
            seq_state_reg <= RWC_SQ_UNSTACK;
          end
        end
        RWC_SQ_STACK: begin
          seq_step_reg <= (seq_step_reg == RWC_STACK_LAST) ? 3'h0 : seq_step_reg + 3'h1;
          if (seq_step_reg == RWC_STACK_LAST) begin
            seq_state_reg <= RWC_SQ_VEC;
          end
        end
        RWC_SQ_UNSTACK: begin
          seq_step_reg <= (seq_step_reg == RWC_STACK_LAST) ? 3'h0 : seq_step_reg + 3'h1;
          if (seq_step_reg == RWC_STACK_LAST) begin
            seq_state_reg <= RWC_SQ_FILL;
          end
        end
        RWC_SQ_VEC: begin
          seq_step_reg <= (seq_step_reg == RWC_VEC_LAST) ? 3'h0 : seq_step_reg + 3'h1;
          if (seq_step_reg == RWC_VEC_LAST) begin
            seq_state_reg <= RWC_SQ_FILL;
          end
        end
        RWC_SQ_FILL: begin
          seq_step_reg <= (seq_step_reg == RWC_FILL_LAST) ? 3'h0 : seq_step_reg + 3'h1;
          if (seq_step_reg == RWC_FILL_LAST) begin
            seq_state_reg <= RWC_SQ_IDLE;
          end
        end
        default: seq_state_reg <= RWC_SQ_IDLE;
      endcase
    end
  end

  wire rwc_op_t seq_op = (seq_state_reg == RWC_SQ_STACK) ? RWC_OP_PUSH :
                         (seq_state_reg == RWC_SQ_UNSTACK) ? RWC_OP_PULL :
                         (seq_state_reg == RWC_SQ_VEC) ? RWC_OP_VECTOR :
                         (seq_state_reg == RWC_SQ_FILL) ? RWC_OP_FILL : RWC_OP_NONE;
  // pulls run in reverse frame order, ccr first
  wire logic [2:0] seq_index = (seq_state_reg == RWC_SQ_UNSTACK) ? RWC_STACK_LAST - seq_step_reg : seq_step_reg;

  // register read mux, sampled at the address phase so data is ready with zero waits
  wire logic [31:0] rd_mux =
    (haddr[7:0] == RWC_OFS_CAUSE) ? {24'h0, cause_reg} :
    (haddr[7:0] == RWC_OFS_OPT1) ? {30'h0, tsel_reg} :
    (haddr[7:0] == RWC_OFS_OPT2) ? {30'h0, window_reg, clksel_reg} :
    (haddr[7:0] == RWC_OFS_WDCNT) ? {12'h0, wd_cnt_reg} :
    (haddr[7:0] == RWC_OFS_IRQ_EN) ? {24'h0, irq_en_reg} :
    (haddr[7:0] == RWC_OFS_IRQ_FLAG) ? {24'h0, irq_flag_reg} :
    (haddr[7:0] == RWC_OFS_GMASK) ? {31'h0, gmask_reg} :
    (haddr[7:0] == RWC_OFS_EXT_MODE) ? {31'h0, level_mode_reg} : 32'h0;
  wire logic addr_hit = haddr[31:8] == 24'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h0;
      rdata_reg <= 32'h0;
    end else begin
      // writes during the reset sequence are dropped
      ph_wr_reg <= addr_ok & hwrite & addr_hit & ~sys_rst & (hsize == 3'h2);
      ph_addr_reg <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        rdata_reg <= addr_hit ? rd_mux : 32'h0;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = rst_state_reg == RWC_RS_DRIVE;
  assign cpu_reset_n = ~sys_rst;
  assign stack_pointer_init = sp_reg;
  assign global_mask = gmask_reg;
  assign irq_request = |irq_req;
  assign cpu_step.op = sys_rst ? RWC_OP_NONE : seq_op;
  assign cpu_step.index = seq_index;
  assign cpu_step.addr = (seq_state_reg == RWC_SQ_VEC) ? vec_addr_reg + {13'h0, seq_step_reg} : 16'h0;

endmodule
`default_nettype wire

// ### bench/rwc_top_props.sv
// rwc_chk: port-level assertions for rwc_top, attached by bind.
// assumes one clock hclk, with hresetn as its asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rwc_chk
  import rwc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic cpu_instr_done,
  input wire logic cpu_reset_n,
  input wire logic [15:0] stack_pointer_init,
  input wire logic global_mask,
  input wire logic irq_request,
  input wire rwc_cpu_step_t cpu_step
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] oe_cnt;
  logic [7:0] wait_cnt;
  logic ext_low;
  wire logic take = irq_request && !global_mask && cpu_instr_done && cpu_reset_n && cpu_step.op == RWC_OP_NONE;
  // a pin held low from outside stretches the wait, so such boots skip the wait check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_cnt <= 8'h00;
      wait_cnt <= 8'h00;
      ext_low <= 1'b0;
    end else begin
      oe_cnt <= rst_pin_oe ? oe_cnt + 8'h01 : 8'h00;
      wait_cnt <= (rst_pin_oe || cpu_reset_n) ? 8'h00 : wait_cnt + 8'h01;
      ext_low <= rst_pin_oe ? 1'b0 : (ext_low || !rst_pin_in);
    end
  end
  sequence s_push5;
    (cpu_step.op == RWC_OP_PUSH) [*5];
  endsequence
  sequence s_vec2;
    (cpu_step.op == RWC_OP_VECTOR) [*2];
  endsequence
  sequence s_fill3;
    (cpu_step.op == RWC_OP_FILL) [*3];
  endsequence
  a_pin_drive_len: assert property ($fell(rst_pin_oe) |-> oe_cnt == 8'h22)
    else $error("reset pin not driven for the fixed count");
  a_pin_sample_wait: assert property ($rose(cpu_reset_n) && !ext_low |-> wait_cnt inside {8'h26, 8'h27})
    else $error("pin sampled at the wrong time");
  a_pin_low_only: assert property (rst_pin_oe |-> !rst_pin_out && !cpu_reset_n)
    else $error("reset pin driven high or processor running");
  a_reset_state: assert property (!cpu_reset_n |-> global_mask && stack_pointer_init == RWC_SP_RESET)
    else $error("mask or stack pointer wrong in reset");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_entry_steps: assert property (take |=> s_push5 ##1 s_vec2 ##1 s_fill3)
    else $error("interrupt entry steps out of order");
  a_entry_mask: assert property (take |=> global_mask [*8])
    else $error("mask not set on interrupt entry");
  a_push_order: assert property (cpu_step.op == RWC_OP_PUSH && $past(cpu_step.op) == RWC_OP_PUSH
    |-> cpu_step.index == $past(cpu_step.index) + 3'h1)
    else $error("push order wrong");
  a_pull_order: assert property (cpu_step.op == RWC_OP_PULL && $past(cpu_step.op) == RWC_OP_PULL
    |-> cpu_step.index == $past(cpu_step.index) - 3'h1)
    else $error("pull order wrong");
  a_vector_pair: assert property (cpu_step.op == RWC_OP_VECTOR && $past(cpu_step.op) != RWC_OP_VECTOR
    |-> !cpu_step.addr[0] ##1 cpu_step.addr == $past(cpu_step.addr) + 16'h0001)
    else $error("vector bytes out of order");
endmodule
bind rwc_top rwc_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
  .cpu_instr_done, .cpu_reset_n, .stack_pointer_init, .global_mask, .irq_request, .cpu_step);
`default_nettype wire

// ### bench/rwc_pin_model.sv
// rwc_pin_model: outside reset circuit on the reset pin, with the pin's pull-up.
// assumes the block only ever drives the pin low, while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module rwc_pin_model (
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic hold_low,
  output logic rst_pin_in
);
  // wired-low: either party pulls down, otherwise the pull-up wins
  assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) && !hold_low;
endmodule
`default_nettype wire

// ### bench/rwc_top_tb.sv
// rwc_top_tb: register-level tests of the reset and watchdog controller.
// assumes short bus-clock timeouts and a 1 kHz tick stand-in every 4 clocks.
`timescale 1ns/1ps
`default_nettype none
module rwc_top_tb
  import rwc_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hold_low = 1'b0, tick_1khz = 1'b0;
  logic debug_mode = 1'b0, stop_mode = 1'b0, ext_irq_pin = 1'b0, cpu_instr_done = 1'b1, cpu_rti = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0, tick_div = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:1] irq_event = 7'h00;
  rwc_rst_src_t rst_src = '0;
  logic rst_pin_in, rst_pin_out, rst_pin_oe, cpu_reset_n, global_mask, irq_request, hreadyout, hresp;
  logic [31:0] hrdata, rd, held;
  logic [15:0] stack_pointer_init;
  rwc_cpu_step_t cpu_step;
  logic [7:0] causes [5] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h00};
  int fails = 0, tests_run = 0, cycles = 0;
  rwc_top #(.WDOG_BUS_T1(64), .WDOG_BUS_T2(128), .WDOG_BUS_T3(256)) u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rst_pin_in,
    .rst_pin_out, .rst_pin_oe, .rst_src, .tick_1khz, .debug_mode, .stop_mode, .ext_irq_pin, .irq_event,
    .cpu_instr_done, .cpu_rti, .cpu_reset_n, .stack_pointer_init, .global_mask, .irq_request, .cpu_step);
  rwc_pin_model u_pin (.rst_pin_out, .rst_pin_oe, .hold_low, .rst_pin_in);
  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    tick_div <= tick_div + 2'h1;
    tick_1khz <= (tick_div == 2'h3);
    cycles++;
    if (cycles > 40000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single-word transfer; address phase held until ready, then data phase until ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask
  task automatic wait_low(input int lim);
    for (int n = 0; n < lim && cpu_reset_n === 1'b1; n++) @(posedge hclk);
    check({31'h0, cpu_reset_n}, 32'h0);
  endtask
  task automatic wait_run();
    for (int n = 0; n < 400 && cpu_reset_n !== 1'b1; n++) @(posedge hclk);
    check({31'h0, cpu_reset_n}, 32'h1);
    // let the boot vector fetch drain before new traffic
    repeat (12) @(posedge hclk);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    wait_run();
    rchk(RWC_OFS_CAUSE, 32'h01);
    rchk(RWC_OFS_OPT1, 32'h3);
    rchk(RWC_OFS_OPT2, 32'h1);
    rchk(RWC_OFS_GMASK, 32'h1);
    check({16'h0, stack_pointer_init}, 32'h00ff);
    rchk(8'h20, 32'h0);
    debug_mode <= 1'b1;
    @(posedge hclk);
    rchk(RWC_OFS_WDCNT, 32'h0);
    debug_mode <= 1'b0;
    $display("test defaults done");
    repeat (200) @(posedge hclk);
    wr(RWC_OFS_CAUSE, RWC_SVC_FIRST);
    wr(RWC_OFS_CAUSE, RWC_SVC_SECOND);
    bus(1'b0, RWC_OFS_WDCNT, 32'h0, rd);
    check({31'h0, rd < 32'h4}, 32'h1);
    rchk(RWC_OFS_CAUSE, 32'h01);
    wr(RWC_OFS_CAUSE, 32'h12);
    wait_low(3);
    wait_run();
    rchk(RWC_OFS_CAUSE, 32'h04);
    $display("test service done");
    repeat (3600) @(posedge hclk);
    check({31'h0, cpu_reset_n}, 32'h1);
    wait_low(800);
    wait_run();
    rchk(RWC_OFS_CAUSE, 32'h04);
    $display("test timeout done");
    hold_low <= 1'b1;
    wait_low(3);
    repeat (100) @(posedge hclk);
    check({31'h0, cpu_reset_n}, 32'h0);
    hold_low <= 1'b0;
    wait_run();
    rchk(RWC_OFS_CAUSE, 32'h02);
    for (int i = 0; i < 5; i++) begin
      rst_src <= rwc_rst_src_t'(5'h10 >> i);
      @(posedge hclk);
      rst_src <= '0;
      wait_low(3);
      wait_run();
      rchk(RWC_OFS_CAUSE, {24'h0, causes[i]});
    end
    $display("test reset sources done");
    wr(RWC_OFS_OPT1, 32'h1);
    wr(RWC_OFS_OPT2, 32'h2);
    wr(RWC_OFS_CAUSE, RWC_SVC_FIRST);
    wait_low(3);
    wait_run();
    wr(RWC_OFS_OPT1, 32'h1);
    wr(RWC_OFS_OPT2, 32'h2);
    wr(RWC_OFS_OPT1, 32'h2);
    rchk(RWC_OFS_OPT1, 32'h1);
    debug_mode <= 1'b1;
    bus(1'b0, RWC_OFS_WDCNT, 32'h0, held);
    repeat (20) @(posedge hclk);
    rchk(RWC_OFS_WDCNT, held);
    debug_mode <= 1'b0;
    do bus(1'b0, RWC_OFS_WDCNT, 32'h0, rd); while (rd < 32'h32 && cpu_reset_n === 1'b1);
    wr(RWC_OFS_CAUSE, RWC_SVC_FIRST);
    wr(RWC_OFS_CAUSE, RWC_SVC_SECOND);
    bus(1'b0, RWC_OFS_WDCNT, 32'h0, rd);
    check({31'h0, rd < 32'h8}, 32'h1);
    wr(RWC_OFS_CAUSE, 32'h0);
    wait_low(3);
    wait_run();
    $display("test window done");
    wr(RWC_OFS_OPT2, 32'h3);
    wr(RWC_OFS_CAUSE, RWC_SVC_FIRST);
    wr(RWC_OFS_CAUSE, RWC_SVC_SECOND);
    check({31'h0, cpu_reset_n}, 32'h1);
    wr(RWC_OFS_OPT1, 32'h0);
    wr(RWC_OFS_IRQ_EN, 32'h24);
    irq_event <= 7'h12;
    @(posedge hclk);
    irq_event <= 7'h00;
    rchk(RWC_OFS_IRQ_FLAG, 32'h24);
    check({31'h0, irq_request}, 32'h1);
    wr(RWC_OFS_GMASK, 32'h0);
    for (int n = 0; n < 30 && cpu_step.op !== RWC_OP_VECTOR; n++) @(posedge hclk);
    check({16'h0, cpu_step.addr}, 32'h0000ffca);
    check({31'h0, global_mask}, 32'h1);
    repeat (8) @(posedge hclk);
    wr(RWC_OFS_IRQ_FLAG, 32'hff);
    cpu_rti <= 1'b1;
    @(posedge hclk);
    cpu_rti <= 1'b0;
    repeat (12) @(posedge hclk);
    rchk(RWC_OFS_IRQ_FLAG, 32'h0);
    wr(RWC_OFS_EXT_MODE, 32'h1);
    ext_irq_pin <= 1'b1;
    wr(RWC_OFS_IRQ_FLAG, 32'h1);
    rchk(RWC_OFS_IRQ_FLAG, 32'h1);
    ext_irq_pin <= 1'b0;
    wr(RWC_OFS_IRQ_FLAG, 32'h1);
    rchk(RWC_OFS_IRQ_FLAG, 32'h0);
    // longer than the default 1 kHz timeout, so an enabled watchdog would have fired
    repeat (4200) @(posedge hclk);
    check({31'h0, cpu_reset_n}, 32'h1);
    $display("test interrupts done");
    conclude();
  end
endmodule
`default_nettype wire
